/* design/clksel_consts.vh */
// register offsets, field positions and reset values of the input select and fault monitor
`ifndef CLKSEL_CONSTS_VH
`define CLKSEL_CONSTS_VH

// global register byte offsets
`define CS_GLOBAL_OFS     12'h000
`define CS_LOS_LIMIT_OFS  12'h004
`define CS_REF_LIMIT_OFS  12'h008
`define CS_STATUS_OFS     12'h00c
`define CS_STICKY_OFS     12'h010

// per-channel block: base, stride and word offsets inside a block
`define CS_CH_BASE        12'h020
`define CS_CH_STRIDE      12'h010
`define CS_CH_CTRL_SUB    2'd0
`define CS_CH_STEP_SUB    2'd1
`define CS_CH_CMD_SUB     2'd2
`define CS_CH_STAT_SUB    2'd3

// global register fields
`define CS_G_EXTREF       0
`define CS_G_LOSEN_LSB    1
`define CS_G_PRESC_LSB    8

// channel control fields
`define CS_C_AUTO         0
`define CS_C_REVERT       1
`define CS_C_MAN_LSB      2
`define CS_C_HITLESS      4
`define CS_C_RAMPED       5
`define CS_C_FASTLOCK     6
`define CS_C_PINSTEP      7
`define CS_C_PRIO_LSB     8

// command fields
`define CS_CMD_UP         0
`define CS_CMD_DOWN       1

// status field positions
`define CS_S_OOF_LSB      8
`define CS_S_LOL_LSB      16

// reset values
`define CS_GLOBAL_RST     32'h0000013e
`define CS_LOS_LIMIT_RST  32'h40404040
`define CS_REF_LIMIT_RST  8'h40
`define CS_CH_CTRL_RST    16'he400
`define CS_STEP_RST       32'h00000000

`endif

/* design/clock_input_select_fault_monitor.v */
// per-channel clock input selection, signal-loss monitors and frequency stepping
`default_nettype none
`include "clksel_consts.vh"

module clock_input_select_fault_monitor #(
  parameter NUM_CH = 4
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire [3:0]           clock_input,
  input  wire                 reference_input_pins,
  input  wire                 freq_step_up,
  input  wire                 freq_step_down,
  input  wire [3:0]           freq_out_of_range_flag,
  input  wire [NUM_CH-1:0]    loop_locked,
  output wire [2*NUM_CH-1:0]  selected_input,
  output wire [NUM_CH-1:0]    holdover,
  output wire [NUM_CH-1:0]    lock_loss_flag,
  output wire [32*NUM_CH-1:0] freq_offset,
  output wire [NUM_CH-1:0]    input_switched,
  output wire [NUM_CH-1:0]    hitless_switch_en,
  output wire [NUM_CH-1:0]    ramped_switch_en,
  output wire [NUM_CH-1:0]    fastlock_en,
  output wire                 external_reference_mode,
  output wire                 crystal_load_caps_en,
  output wire [7:0]           reference_prescaler,
  output wire [4:0]           signal_loss_flag
);

  localparam [3:0] ST_FREE   = 4'b0001;
  localparam [3:0] ST_ACQ    = 4'b0010;
  localparam [3:0] ST_LOCKED = 4'b0100;
  localparam [3:0] ST_HOLD   = 4'b1000;

  // highest priority eligible input; priority 0 never chosen, ties go to lower index
  function [2:0] pick_best;
    input [3:0] valid;
    input [7:0] prio;
    integer     i;
    reg   [1:0] bp;
    begin
      pick_best = 3'b000;
      bp        = 2'b00;
      for (i = 0; i < 4; i = i + 1) begin
        if (valid[i] && (prio[2*i +: 2] > bp)) begin
          bp        = prio[2*i +: 2];
          pick_best = {1'b1, i[1:0]};
        end
      end
    end
  endfunction

  // true when a bus access points at the command word of channel chan
  function ch_cmd;
    input [7:0]   idx;
    input [1:0]   word;
    input integer chan;
    begin
      ch_cmd = (idx == chan) && (word == `CS_CH_CMD_SUB);
    end
  endfunction

  // true when the chosen source of a channel is no longer usable
  function src_lost;
    input [4:0] live;
    input [1:0] src;
    begin
      src_lost = live[src];
    end
  endfunction

  // register file
  reg  [31:0]          glob;
  reg  [31:0]          los_limit;
  reg  [7:0]           ref_limit;
  reg  [4:0]           los_sticky;
  reg  [16*NUM_CH-1:0] ch_ctrl_v;
  reg  [32*NUM_CH-1:0] step_v;
  reg  [31:0]          rd_data;

  // pin synchroniser stages
  reg  [6:0]           sync1;
  reg  [6:0]           sync2;
  reg  [6:0]           sync3;

  // status and decode nets
  wire [4:0]           los_live;
  wire [3:0]           eligible;
  wire [4*NUM_CH-1:0]  mode_v;
  wire [NUM_CH-1:0]    cmd_up;
  wire [NUM_CH-1:0]    cmd_down;
  wire [6:0]           rise;
  wire [11:0]          ch_off;
  wire [7:0]           ch_idx;
  wire [1:0]           sub;
  wire                 in_ch;
  wire                 hit;
  wire                 wr_en;
  wire [4:0]           sticky_clr;

  // apb decode
  // channel blocks sit above the global words; any other address answers with pslverr
  // pready is tied high, so every access completes in its first access cycle
  assign ch_off = paddr - `CS_CH_BASE;
  assign ch_idx = ch_off[11:4];
  assign sub    = ch_off[3:2];
  assign in_ch  = (paddr >= `CS_CH_BASE) && (ch_idx < NUM_CH);
  assign hit    = (paddr[1:0] == 2'b00) && (in_ch || (paddr <= `CS_STICKY_OFS));
  assign wr_en  = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  assign sticky_clr = (wr_en && (paddr == `CS_STICKY_OFS)) ? pwdata[4:0] : 5'h00;

  // register writes land on the access edge; the sticky word is cleared apart
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob      <= `CS_GLOBAL_RST;
      los_limit <= `CS_LOS_LIMIT_RST;
      ref_limit <= `CS_REF_LIMIT_RST;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        ch_ctrl_v[16*k +: 16] <= `CS_CH_CTRL_RST;
        step_v[32*k +: 32]    <= `CS_STEP_RST;
      end
    end else if (wr_en) begin
      if (in_ch) begin
        if (sub == `CS_CH_CTRL_SUB)
          ch_ctrl_v[16*ch_idx +: 16] <= pwdata[15:0];
        if (sub == `CS_CH_STEP_SUB)
          step_v[32*ch_idx +: 32] <= pwdata;
      end else begin
        case (paddr)
          `CS_GLOBAL_OFS:    glob      <= pwdata;
          `CS_LOS_LIMIT_OFS: los_limit <= pwdata;
          `CS_REF_LIMIT_OFS: ref_limit <= pwdata[7:0];
          default:           glob      <= glob;
        endcase
      end
    end
  end

  // read data is latched in the setup cycle, valid throughout the access phase
  always @* begin
    rd_data = 32'h00000000;
    if (in_ch) begin
      case (sub)
        `CS_CH_CTRL_SUB: rd_data[15:0] = ch_ctrl_v[16*ch_idx +: 16];
        `CS_CH_STEP_SUB: rd_data       = step_v[32*ch_idx +: 32];
        `CS_CH_CMD_SUB:  rd_data       = freq_offset[32*ch_idx +: 32];
        default: begin
          rd_data[3:0] = mode_v[4*ch_idx +: 4];
          rd_data[5:4] = selected_input[2*ch_idx +: 2];
        end
      endcase
    end else begin
      case (paddr)
        `CS_GLOBAL_OFS:    rd_data = glob;
        `CS_LOS_LIMIT_OFS: rd_data = los_limit;
        `CS_REF_LIMIT_OFS: rd_data[7:0] = ref_limit;
        `CS_STATUS_OFS: begin
          rd_data[4:0]                   = los_live;
          rd_data[`CS_S_OOF_LSB +: 4]    = freq_out_of_range_flag;
          rd_data[`CS_S_LOL_LSB +: NUM_CH] = lock_loss_flag;
        end
        `CS_STICKY_OFS:    rd_data[4:0] = los_sticky;
        default:           rd_data = 32'h00000000;
      endcase
    end
  end

  // writes and unmapped reads leave zero on the read bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      if (hit && !pwrite)
        prdata <= rd_data;
      else
        prdata <= 32'h00000000;
    end
  end

  // reference selection and prescaler
  assign external_reference_mode = glob[`CS_G_EXTREF];
  assign crystal_load_caps_en    = !glob[`CS_G_EXTREF];
  assign reference_prescaler     = glob[`CS_G_PRESC_LSB +: 8];

  // pin synchronisers: four inputs, reference, step up, step down
  // sync3 only feeds the edge detector; nothing but sync2 reads sync1
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      sync3 <= 7'h00;
    end else begin
      sync1 <= {freq_step_down, freq_step_up, reference_input_pins, clock_input};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign rise = sync2 & ~sync3;

  // signal-loss monitors: limit is the longest edge-free gap in pclk cycles
  // a legal gapped input leaves at most three periods without an edge, so the
  // default limit sits well above that gap and swallowed cycles raise no flag
  genvar m;
  generate
    for (m = 0; m < 5; m = m + 1) begin : g_los
      wire [7:0] lim = (m < 4) ? los_limit[8*(m % 4) +: 8] : ref_limit;
      wire       en  = glob[`CS_G_LOSEN_LSB + m];
      reg  [7:0] cnt;
      reg        live;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt  <= 8'h00;
          live <= 1'b0;
        end else if (!en || rise[m]) begin
          cnt  <= 8'h00;
          live <= 1'b0;
        end else if (cnt >= lim) begin
          live <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
      assign los_live[m] = live;
    end
  endgenerate

  // sticky bits: a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_sticky <= 5'h00;
    end else begin
      los_sticky <= (los_sticky & ~sticky_clr) | los_live;
    end
  end

  assign signal_loss_flag = los_live;
  assign eligible = ~los_live[3:0] & ~freq_out_of_range_flag;

  // channels: each one picks its own input from the shared crossbar
  // and keeps its own mode, selection and frequency offset
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      wire [15:0] ctl  = ch_ctrl_v[16*c +: 16];
      wire [2:0]  best = pick_best(eligible, ctl[`CS_C_PRIO_LSB +: 8]);
      wire        up;
      wire        down;
      reg  [3:0]  state;
      reg  [1:0]  sel;
      reg  [31:0] freq;
      reg         sw;
      reg  [1:0]  want;
      reg         want_ok;

      assign cmd_up[c]   = wr_en && in_ch && ch_cmd(ch_idx, sub, c) && pwdata[`CS_CMD_UP];
      assign cmd_down[c] = wr_en && in_ch && ch_cmd(ch_idx, sub, c) && pwdata[`CS_CMD_DOWN];

      // pin requests reach only channels that opted in to pin stepping
      assign up   = cmd_up[c] || (ctl[`CS_C_PINSTEP] && rise[5]);
      assign down = cmd_down[c] || (ctl[`CS_C_PINSTEP] && rise[6]);

      // input wanted by the selection method
      // manual mode looks only at signal loss; automatic mode also at frequency
      always @* begin
        if (!ctl[`CS_C_AUTO]) begin
          want    = ctl[`CS_C_MAN_LSB +: 2];
          want_ok = !src_lost(los_live, ctl[`CS_C_MAN_LSB +: 2]);
        end else if (!ctl[`CS_C_REVERT] && ((state == ST_ACQ) || (state == ST_LOCKED))
                     && eligible[sel]) begin
          want    = sel;
          want_ok = 1'b1;
        end else begin
          want    = best[1:0];
          want_ok = best[2];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state <= ST_FREE;
          sel   <= 2'b00;
          sw    <= 1'b0;
        end else begin
          sw <= 1'b0;
          case (state)
            // leave free-run or holdover as soon as a usable input appears
            ST_FREE, ST_HOLD: begin
              if (want_ok) begin
                state <= ST_ACQ;
                sel   <= want;
                sw    <= 1'b1;
              end
            end
            // a lost source wins over a better one; a new source restarts acquisition
            ST_ACQ, ST_LOCKED: begin
              if (!want_ok) begin
                state <= ST_HOLD;
              end else if (want != sel) begin
                state <= ST_ACQ;
                sel   <= want;
                sw    <= 1'b1;
              end else if ((state == ST_ACQ) && loop_locked[c]) begin
                state <= ST_LOCKED;
              end
            end
            default: state <= ST_FREE;
          endcase
        end
      end

      // frequency stepping; simultaneous up and down cancel
      // requests outside free-run or locked are dropped, not queued
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          freq <= 32'h00000000;
        end else if ((state == ST_FREE) || (state == ST_LOCKED)) begin
          if (up && !down)
            freq <= freq + step_v[32*c +: 32];
          else if (down && !up)
            freq <= freq - step_v[32*c +: 32];
        end
      end

      // status and per-channel controls for the loop datapath
      assign mode_v[4*c +: 4]          = state;
      assign selected_input[2*c +: 2]  = sel;
      assign holdover[c]               = (state == ST_HOLD);
      assign lock_loss_flag[c]         = (state != ST_LOCKED);
      assign freq_offset[32*c +: 32]   = freq;
      assign input_switched[c]         = sw;
      assign hitless_switch_en[c]      = ctl[`CS_C_HITLESS];
      assign ramped_switch_en[c]       = ctl[`CS_C_RAMPED];
      assign fastlock_en[c]            = ctl[`CS_C_FASTLOCK];
    end
  endgenerate

endmodule // clock_input_select_fault_monitor
`default_nettype wire

/* test/clksel_checker.sv */
// port assertions for the clock input select and fault monitor
`default_nettype none
module clksel_checker #(
  parameter NUM_CH = 4
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic [3:0]           clock_input,
  input wire logic [3:0]           freq_out_of_range_flag,
  input wire logic [NUM_CH-1:0]    loop_locked,
  input wire logic [2*NUM_CH-1:0]  selected_input,
  input wire logic [NUM_CH-1:0]    holdover,
  input wire logic [NUM_CH-1:0]    lock_loss_flag,
  input wire logic [32*NUM_CH-1:0] freq_offset,
  input wire logic [NUM_CH-1:0]    input_switched,
  input wire logic                 external_reference_mode,
  input wire logic                 crystal_load_caps_en,
  input wire logic [4:0]           signal_loss_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_caps_off: assert property (crystal_load_caps_en != external_reference_mode)
    else $error("caps enable not inverse of reference mode");
  a_switch_lock: assert property (input_switched[0] |-> lock_loss_flag[0])
    else $error("input switch without lock loss");
  a_lock_clear: assert property ($fell(lock_loss_flag[0]) |-> $past(loop_locked[0]))
    else $error("lock loss cleared while loop unlocked");
  a_hold_cause: assert property ($rose(holdover[0]) |->
    $past((|signal_loss_flag[3:0]) || (|freq_out_of_range_flag)))
    else $error("holdover entered without a fault");
  a_step_mode: assert property ($changed(freq_offset[31:0]) |-> !$past(holdover[0]))
    else $error("frequency stepped in holdover");
  a_sel_pulse: assert property ($changed(selected_input[1:0]) |-> input_switched[0])
    else $error("selection changed without switch pulse");
  a_loss_late: assert property ($rose(clock_input[0]) |->
    ##3 (!$rose(signal_loss_flag[0])) [*8])
    else $error("loss flagged right after an edge");
  a_live_clear: assert property ($rose(clock_input[0]) && signal_loss_flag[0] |->
    ##[1:5] !signal_loss_flag[0])
    else $error("live loss kept after edges returned");

  c_hold: cover property ($rose(holdover[0]));
  c_switch: cover property (input_switched[0]);
  c_loss: cover property ($rose(signal_loss_flag[0]));
endmodule // clksel_checker
`default_nettype wire

/* test/clk_sources.sv */
// upstream clock sources: gapped inputs and a reference, each can be stopped
`default_nettype none
module clk_sources (
  input  wire logic [4:0] run,
  output logic      [3:0] clock_input,
  output logic            reference_input_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       src = 1'b0;
  logic [2:0] phase = 3'h0;
  always #17 src = ~src;
  // gap chosen while low so no runt pulse appears
  always @(negedge src) phase <= phase + 3'h1;
  // two of every eight cycles swallowed, about 29 MHz
  assign clock_input = run[3:0] & {4{src & (phase < 3'h6)}};
  assign reference_input_pins = run[4] & src;
endmodule // clk_sources
`default_nettype wire

/* test/clock_input_select_fault_monitor_tb_top.sv */
// self-checking bench for the clock input select and fault monitor
`default_nettype none
module clock_input_select_fault_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] all = 32'hffffffff;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr;
  logic [4:0]  run = 5'h10;
  logic [3:0]  clock_input, selected_input;
  logic        reference_input_pins;
  logic        freq_step_up = 1'b0;
  logic        freq_step_down = 1'b0;
  logic [1:0]  hitless_switch_en, ramped_switch_en, fastlock_en;
  logic [3:0]  freq_out_of_range_flag = 4'h0;
  logic [1:0]  loop_locked = 2'h0;
  logic [1:0]  holdover, lock_loss_flag, input_switched;
  logic [63:0] freq_offset;
  logic        external_reference_mode, crystal_load_caps_en;
  logic [7:0]  reference_prescaler;
  logic [4:0]  signal_loss_flag;
  int          bad_count = 0;
  int          checked = 0;
  int          cycles = 0;

  clock_input_select_fault_monitor #(.NUM_CH(2)) i_clock_input_select_fault_monitor (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .clock_input, .reference_input_pins, .freq_step_up,
    .freq_step_down, .freq_out_of_range_flag, .loop_locked, .selected_input,
    .holdover, .lock_loss_flag, .freq_offset, .input_switched, .hitless_switch_en,
    .ramped_switch_en, .fastlock_en, .external_reference_mode,
    .crystal_load_caps_en, .reference_prescaler, .signal_loss_flag
  );
  clk_sources i_clk_sources (.run, .clock_input, .reference_input_pins);

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask
  task automatic wait_hold(input logic v);
    for (int i = 0; i < 300 && holdover[0] !== v; i++) @(posedge pclk);
    chk({31'h0, holdover[0]}, {31'h0, v});
  endtask

  task automatic t_regs();
    rd(12'h000, all, 32'h0000013e);
    rd(12'h004, all, 32'h40404040);
    rd(12'h008, all, 32'h00000040);
    rd(12'h030, all, 32'h0000e400);
    rd(12'hffc, all, 32'h00000000);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, 12'h000, 32'h0000053f);
    chk({30'h0, crystal_load_caps_en, external_reference_mode}, 32'h1);
    chk({24'h0, reference_prescaler}, 32'h5);
    apb(1'b1, 12'h000, 32'h0000013e);
    apb(1'b1, 12'h020, 32'h0000e470);
    chk({31'h0, hitless_switch_en[0]}, 32'h1);
    chk({31'h0, ramped_switch_en[0]}, 32'h1);
    chk({31'h0, fastlock_en[0]}, 32'h1);
    apb(1'b1, 12'h020, 32'h0000e400);
    chk({31'h0, hitless_switch_en[0]}, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_step();
    wait_hold(1'b1);
    apb(1'b1, 12'h024, 32'h100);
    apb(1'b1, 12'h028, 32'h1);
    chk(freq_offset[31:0], 32'h0);
    run <= 5'h1f;
    loop_locked <= 2'h3;
    wait_hold(1'b0);
    cyc(3);
    chk({31'h0, lock_loss_flag[0]}, 32'h0);
    apb(1'b1, 12'h028, 32'h1);
    chk(freq_offset[31:0], 32'h100);
    apb(1'b1, 12'h028, 32'h2);
    apb(1'b1, 12'h028, 32'h2);
    rd(12'h028, all, 32'hffffff00);
    apb(1'b1, 12'h020, 32'he480);
    freq_step_up <= 1'b1;
    cyc(6);
    chk(freq_offset[31:0], 32'h0);
    freq_step_up <= 1'b0;
    freq_step_down <= 1'b1;
    cyc(6);
    chk(freq_offset[31:0], 32'hffffff00);
    freq_step_down <= 1'b0;
    $display("t_step done");
  endtask
  task automatic t_loss();
    run <= 5'h1e;
    wait_hold(1'b1);
    chk({27'h0, signal_loss_flag}, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    rd(12'h010, 32'h1, 32'h1);
    apb(1'b1, 12'h000, 32'h13c);
    cyc(2);
    chk({27'h0, signal_loss_flag}, 32'h0);
    apb(1'b1, 12'h000, 32'h13e);
    run <= 5'h1f;
    cyc(100);
    chk({27'h0, signal_loss_flag}, 32'h0);
    apb(1'b1, 12'h010, 32'h1f);
    rd(12'h010, 32'h1f, 32'h0);
    $display("t_loss done");
  endtask
  task automatic t_auto();
    apb(1'b1, 12'h020, 32'h2d03);
    apb(1'b1, 12'h030, 32'he40c);
    cyc(4);
    chk({28'h0, selected_input}, 32'hd);
    freq_out_of_range_flag <= 4'h2;
    cyc(4);
    chk({30'h0, selected_input[1:0]}, 32'h2);
    rd(12'h00c, 32'hf00, 32'h200);
    freq_out_of_range_flag <= 4'hf;
    cyc(4);
    chk({31'h0, holdover[0]}, 32'h1);
    freq_out_of_range_flag <= 4'h0;
    cyc(4);
    chk({30'h0, selected_input[1:0]}, 32'h1);
    $display("t_auto done");
  endtask

  initial begin
    cyc(5);
    presetn <= 1'b1;
    t_regs();
    t_step();
    t_loss();
    t_auto();
    end_sim();
  end
endmodule // clock_input_select_fault_monitor_tb_top

bind clock_input_select_fault_monitor clksel_checker #(.NUM_CH(NUM_CH)) i_clksel_checker (
  .pclk, .presetn, .clock_input, .freq_out_of_range_flag, .loop_locked, .selected_input,
  .holdover, .lock_loss_flag, .freq_offset, .input_switched, .external_reference_mode,
  .crystal_load_caps_en, .signal_loss_flag
);
`default_nettype wire
